// ==== design/smsbg_pkg.sv ====
package smsbg_pkg;

    // register offsets on the plain port
    localparam logic [2:0] ADDR_DIV_LO    = 3'h0;
    localparam logic [2:0] ADDR_DIV_HI    = 3'h1;
    localparam logic [2:0] ADDR_IRQ_EN    = 3'h2;
    localparam logic [2:0] ADDR_LINE_STAT = 3'h3;
    localparam logic [2:0] ADDR_MODEM_CTL = 3'h4;
    localparam logic [2:0] ADDR_MODEM_ST  = 3'h5;
    localparam logic [2:0] ADDR_IRQ_STAT  = 3'h6;
    localparam logic [2:0] ADDR_IRQ_MASK  = 3'h7;

    // modem status fields
    localparam int DELTA_CTS_BIT = 0;
    localparam int DELTA_DSR_BIT = 1;
    localparam int RING_TE_BIT   = 2;
    localparam int DELTA_DCD_BIT = 3;
    // modem control fields, and the modem interrupt enable bit
    localparam int MCTL_DTR_BIT  = 0;
    localparam int MCTL_RTS_BIT  = 1;
    localparam int MCTL_AUX1_BIT = 2;
    localparam int MCTL_AUX2_BIT = 3;
    localparam int MCTL_LOOP_BIT = 4;
    localparam int IRQ_EN_MODEM_BIT = 3;
    // interrupt status bits
    localparam int EVT_MODEM_BIT = 0;
    localparam int EVT_TICK_BIT  = 1;

    localparam logic [7:0]  MCTL_WMASK  = 8'h1f;
    localparam logic [7:0]  IRQ_EN_WMASK = 8'h0f;
    localparam logic [15:0] DIV_RESET   = 16'h0001;
    localparam int          TICK_RATIO  = 16;
    localparam int          MSI_PRIORITY = 4;

    // line status flag inputs, deferred like modem deltas
    localparam int LINE_FLAGS = 8;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } smsbg_req_t;

    // modem inputs, active high meaning asserted
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } smsbg_modem_t;

endpackage : smsbg_pkg

// ==== design/smsbg_baud.sv ====
`timescale 1ns/1ps
module smsbg_baud #(
    parameter int DIV_W = 16
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // divisor
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic             reload,
    // tick
    output logic                  tick16
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } smsbg_baud_st_t;

    smsbg_baud_st_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (reload) begin
            st_d.cnt = divisor;
        end else if (st_q.cnt <= DIV_W'(1)) begin
            st_d.tick = (divisor != '0);
            st_d.cnt  = divisor;
        end else begin
            st_d.cnt = st_q.cnt - DIV_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign tick16 = st_q.tick;

    ////////////////////////////////////////////////////////////////////////////
    tick_div_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && $past(clk_en) && divisor == DIV_W'(1) && !reload && !$past(reload)
         && st_q.tick) |=> !clk_en || tick16)
        else $error("tick not steady with divisor one");
    reload_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_en && reload) |=> st_q.cnt == $past(divisor))
        else $error("counter not reloaded on divisor write");
    tick_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (tick16 && divisor > DIV_W'(1) && clk_en && !reload) |=> !tick16)
        else $error("tick longer than one cycle");
    tick_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n) tick16);

endmodule : smsbg_baud

// ==== design/smsbg_top.sv ====
// Operation
// - modem status read clears deltas only
// - flags set deferred until read strobe ends
// - repeat during read of set flag clears
// - loopback ignores external modem input pins
// - loopback control writes raise modem interrupt
// - divide reference by divisor 1 to 65535
// - tick runs at sixteen times bit rate
// - divisor kept in two byte latches
// - latch write reloads baud counter immediately
// - rates 50 bit/s to 512 kbit/s
// - delta set on change, cleared on read
// - ring flag only on low to high
// - enabled deltas request priority four interrupt
// - loopback status bits follow control outputs
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module smsbg_top #(
    parameter int DIV_W = 16
) (
    // clock, reset, enable
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    // register port
    input  wire logic [2:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [7:0]                 reg_rdata,
    // modem pins, active low
    input  wire logic                       cts_n,
    input  wire logic                       dsr_n,
    input  wire logic                       ri_n,
    input  wire logic                       dcd_n,
    output logic                            dtr_n,
    output logic                            rts_n,
    output logic                            aux_output_one_n,
    output logic                            aux_output_two_n,
    // line status event inputs from the channel
    input  wire logic [smsbg_pkg::LINE_FLAGS-1:0] line_events,
    // results
    output logic                            tick16,
    output logic                            modem_irq,
    output logic                            irq
);

    typedef struct packed {
        logic [3:0]              sync1;
        logic [3:0]              sync2;
        smsbg_pkg::smsbg_modem_t live;
        logic [3:0]              delta;
        logic [3:0]              pend_set;
        logic [3:0]              pend_clr;
        logic [7:0]              line_stat;
        logic [7:0]              line_pset;
        logic [7:0]              line_pclr;
        logic [7:0]              div_lo;
        logic [7:0]              div_hi;
        logic [7:0]              mctl;
        logic [7:0]              irq_en;
        logic [1:0]              evt;
        logic [1:0]              mask;
        logic [7:0]              rdata;
        logic                    rd_ms;
        logic                    rd_ls;
        logic                    mirq;
        logic                    irq;
        logic [3:0]              mout_n;
    } smsbg_st_t;

    smsbg_st_t st_q, st_d;
    logic      reload;
    logic      tick_w;

    // apply one strobe-deferred flag bank at trailing edge of its read
    function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] ev,
                                             input logic [7:0] pset, input logic [7:0] pclr,
                                             input logic rd, input logic rd_end,
                                             input logic [7:0] clr_mask);
        logic [7:0] r;
        r = cur;
        if (rd_end) begin
            r = ((cur & ~clr_mask) | pset) & ~pclr;
        end
        if (!rd) begin
            r = r | ev;
        end
        return r;
    endfunction : flag_next

    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] src;
    logic [7:0] dnext;
    logic [3:0] ev;
    logic       rd_ms_now;
    logic       rd_ls_now;
    logic       ms_end;
    logic       ls_end;

    always_comb begin
        st_d = st_q;
        rd_ms_now = reg_rd && reg_addr == smsbg_pkg::ADDR_MODEM_ST;
        rd_ls_now = reg_rd && reg_addr == smsbg_pkg::ADDR_LINE_STAT;
        ms_end = st_q.rd_ms && !rd_ms_now;
        ls_end = st_q.rd_ls && !rd_ls_now;
        reload = 1'b0;

        // pins through two flops before use
        st_d.sync1 = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
        st_d.sync2 = st_q.sync1;

        // loopback feeds control bits to status, pins ignored
        if (st_q.mctl[smsbg_pkg::MCTL_LOOP_BIT]) begin
            src = {st_q.mctl[smsbg_pkg::MCTL_AUX2_BIT], st_q.mctl[smsbg_pkg::MCTL_AUX1_BIT],
                   st_q.mctl[smsbg_pkg::MCTL_DTR_BIT], st_q.mctl[smsbg_pkg::MCTL_RTS_BIT]};
        end else begin
            src = st_q.sync2;
        end
        st_d.live = src;

        ev = st_q.live ^ src;
        // trailing edge: ring pin returns high, so the asserted level falls
        ev[smsbg_pkg::RING_TE_BIT] = st_q.live.ri && !src[2];

        // deferral bookkeeping while a read strobe is high
        if (rd_ms_now) begin
            st_d.pend_set = st_q.pend_set | (ev & ~st_q.delta);
            st_d.pend_clr = st_q.pend_clr | (ev & st_q.delta);
        end else begin
            st_d.pend_set = '0;
            st_d.pend_clr = '0;
        end
        if (rd_ls_now) begin
            st_d.line_pset = st_q.line_pset | (line_events & ~st_q.line_stat);
            st_d.line_pclr = st_q.line_pclr | (line_events & st_q.line_stat);
        end else begin
            st_d.line_pset = '0;
            st_d.line_pclr = '0;
        end

        dnext = flag_next({4'h0, st_q.delta}, {4'h0, ev}, {4'h0, st_q.pend_set},
                          {4'h0, st_q.pend_clr}, rd_ms_now, ms_end, 8'h0f);
        st_d.delta = dnext[3:0];
        st_d.line_stat = flag_next(st_q.line_stat, line_events, st_q.line_pset,
                                   st_q.line_pclr, rd_ls_now, ls_end, 8'hff);
        st_d.rd_ms = rd_ms_now;
        st_d.rd_ls = rd_ls_now;

        // writes; modem status writes are dropped
        if (reg_wr) begin
            unique case (reg_addr)
                smsbg_pkg::ADDR_DIV_LO: begin
                    st_d.div_lo = reg_wdata;
                    reload = 1'b1;
                end
                smsbg_pkg::ADDR_DIV_HI: begin
                    st_d.div_hi = reg_wdata;
                    reload = 1'b1;
                end
                smsbg_pkg::ADDR_IRQ_EN:    st_d.irq_en = reg_wdata & smsbg_pkg::IRQ_EN_WMASK;
                smsbg_pkg::ADDR_MODEM_CTL: st_d.mctl = reg_wdata & smsbg_pkg::MCTL_WMASK;
                smsbg_pkg::ADDR_IRQ_MASK:  st_d.mask = reg_wdata[1:0];
                default: ;
            endcase
        end

        // read data, one cycle later
        st_d.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                smsbg_pkg::ADDR_DIV_LO:    st_d.rdata = st_q.div_lo;
                smsbg_pkg::ADDR_DIV_HI:    st_d.rdata = st_q.div_hi;
                smsbg_pkg::ADDR_IRQ_EN:    st_d.rdata = st_q.irq_en;
                smsbg_pkg::ADDR_LINE_STAT: st_d.rdata = st_q.line_stat;
                smsbg_pkg::ADDR_MODEM_CTL: st_d.rdata = st_q.mctl;
                smsbg_pkg::ADDR_MODEM_ST:  st_d.rdata = {st_q.live, st_q.delta};
                smsbg_pkg::ADDR_IRQ_STAT:  st_d.rdata = {6'h00, st_q.evt};
                smsbg_pkg::ADDR_IRQ_MASK:  st_d.rdata = {6'h00, st_q.mask};
                default:                   st_d.rdata = 8'h00;
            endcase
        end

        // sticky events; a new event beats the read clear
        if (reg_rd && reg_addr == smsbg_pkg::ADDR_IRQ_STAT) begin
            st_d.evt = '0;
        end
        st_d.evt[smsbg_pkg::EVT_MODEM_BIT] = st_d.evt[smsbg_pkg::EVT_MODEM_BIT] | st_q.mirq;
        st_d.evt[smsbg_pkg::EVT_TICK_BIT]  = st_d.evt[smsbg_pkg::EVT_TICK_BIT] | tick_w;

        st_d.mirq = st_q.irq_en[smsbg_pkg::IRQ_EN_MODEM_BIT] && (st_d.delta != 4'h0);
        st_d.irq  = (st_d.evt & st_d.mask) != 2'b00;

        // outputs idle high in loopback
        if (st_d.mctl[smsbg_pkg::MCTL_LOOP_BIT]) begin
            st_d.mout_n = 4'hf;
        end else begin
            st_d.mout_n = ~st_d.mctl[3:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q        <= '0;
            st_q.div_lo <= smsbg_pkg::DIV_RESET[7:0];
            st_q.div_hi <= smsbg_pkg::DIV_RESET[15:8];
            st_q.mout_n <= 4'hf;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    smsbg_baud #(
        .DIV_W (DIV_W)
    ) u_baud (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .divisor  (DIV_W'({st_d.div_hi, st_d.div_lo})),
        .reload   (reload),
        .tick16   (tick_w)
    );

    assign reg_rdata        = st_q.rdata;
    assign dtr_n            = st_q.mout_n[smsbg_pkg::MCTL_DTR_BIT];
    assign rts_n            = st_q.mout_n[smsbg_pkg::MCTL_RTS_BIT];
    assign aux_output_one_n = st_q.mout_n[smsbg_pkg::MCTL_AUX1_BIT];
    assign aux_output_two_n = st_q.mout_n[smsbg_pkg::MCTL_AUX2_BIT];
    assign tick16           = tick_w;
    assign modem_irq        = st_q.mirq;
    assign irq              = st_q.irq;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    ms_read_live_a: assert property ((clk_en && rd_ms_now) |=>
        (!clk_en || st_q.live == $past(src)))
        else $error("live bits disturbed by status read");
    defer_set_a: assert property ((clk_en && st_q.rd_ms && rd_ms_now) |=>
        (!clk_en || (st_q.delta & ~$past(st_q.delta)) == 4'h0))
        else $error("delta set during read strobe");
    repeat_clr_a: assert property ((clk_en && ms_end && st_q.pend_clr != 4'h0) |=>
        (!clk_en || ($past(st_q.pend_clr) & st_q.delta & ~$past(ev)) == 4'h0))
        else $error("repeated event did not clear flag");
    loop_ignore_a: assert property ((clk_en && st_q.mctl[4] && $past(st_q.mctl[4])
        && $stable(st_q.mctl)) |-> src == st_q.live)
        else $error("pins leak into loopback status");
    loop_cts_a: assert property ((clk_en && st_q.mctl[smsbg_pkg::MCTL_LOOP_BIT]) |=>
        (!clk_en || st_q.live.cts == $past(st_q.mctl[smsbg_pkg::MCTL_RTS_BIT])))
        else $error("loopback cts does not follow rts");
    ring_edge_a: assert property ((clk_en && !rd_ms_now && !st_q.live.ri && src[2]
        && !st_q.delta[2]) |=> (!clk_en || !st_q.delta[2]))
        else $error("ring falling edge set flag");
    irq_level_a: assert property ((clk_en && st_q.irq_en[3] && st_q.delta != 4'h0
        && $stable(st_q.delta) && $stable(st_q.irq_en)) |-> modem_irq)
        else $error("modem interrupt missing");
    delta_set_a: assert property ((clk_en && !rd_ms_now && !st_q.rd_ms && ev[0]) |=>
        (!clk_en || st_q.delta[0]))
        else $error("delta cts not set on change");
    loop_irq_c:   cover property (st_q.mctl[4] && modem_irq);
    deferred_c:   cover property (ms_end && st_q.pend_set != 4'h0);
    repeat_clr_c: cover property (ms_end && st_q.pend_clr != 4'h0);

endmodule : smsbg_top

// ==== tb/smsbg_modem_model.sv ====
`timescale 1ns/1ps
module smsbg_modem_model (
    // clock and wanted line states from the bench
    input  wire logic                    core_clk,
    input  wire smsbg_pkg::smsbg_modem_t want,
    input  wire logic                    slow,
    // modem pins, active low
    output logic                         cts_n,
    output logic                         dsr_n,
    output logic                         ri_n,
    output logic                         dcd_n
);
    smsbg_pkg::smsbg_modem_t line_q = '0;
    int unsigned             wait_q = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // a slow modem settles changes late, so the pin sync sees odd phases
    always @(posedge core_clk) begin
        if (want != line_q && wait_q < (slow ? 5 : 0)) begin
            wait_q <= wait_q + 1;
        end else begin
            line_q <= want;
            wait_q <= 0;
        end
    end

    // pins are levels, held until the modem changes them
    assign cts_n = ~line_q.cts;
    assign dsr_n = ~line_q.dsr;
    assign ri_n  = ~line_q.ri;
    assign dcd_n = ~line_q.dcd;
endmodule : smsbg_modem_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic                    core_clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic [2:0]              reg_addr = 3'h0;
    logic [7:0]              reg_wdata = 8'h00;
    logic                    reg_wr = 1'b0;
    logic                    reg_rd = 1'b0;
    logic [7:0]              line_events = 8'h00;
    smsbg_pkg::smsbg_modem_t want = '0;
    logic                    slow = 1'b0;
    logic                    clk_en = 1'b1;
    logic [7:0]              reg_rdata;
    logic                    cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n;
    logic                    aux_output_one_n, aux_output_two_n, tick16, modem_irq, irq;
    int                      err_total = 0;
    int                      samples_checked = 0;
    int                      cyc = 0;
    int                      n;
    logic [7:0]              d;
    logic [15:0]             divs [7] = '{16'hffff, 16'h0003, 16'h0001, 16'h000c,
                                          16'h0900, 16'h0014, 16'h0005};
    logic [7:0]              lb [5][2] = '{'{8'h12, 8'h11}, '{8'h11, 8'h23},
                                           '{8'h14, 8'h42}, '{8'h18, 8'h8c}, '{8'h10, 8'h08}};

    always #20 core_clk = ~core_clk;

    smsbg_top #(.DIV_W(16)) u_smsbg_top (.core_clk, .rst_n, .clk_en, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cts_n, .dsr_n, .ri_n, .dcd_n, .dtr_n,
        .rts_n, .aux_output_one_n, .aux_output_two_n, .line_events, .tick16, .modem_irq,
        .irq);
    smsbg_modem_model u_smsbg_modem_model (.core_clk, .want, .slow, .cts_n, .dsr_n,
        .ri_n, .dcd_n);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // events ride beside the strobe so a flag can arise during the read
    task automatic rd(input logic [2:0] a, input logic [7:0] ev, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd      <= 1'b1;
        reg_addr    <= a;
        line_events <= ev;
        @(posedge core_clk);
        reg_rd      <= 1'b0;
        line_events <= 8'h00;
        #1 v = reg_rdata;
    endtask : rd

    task automatic rdchk(input logic [2:0] a, input logic [7:0] ev, input logic [7:0] exp,
                         input logic [7:0] msk);
        logic [7:0] v;
        rd(a, ev, v);
        chk_val({8'h00, v & msk}, {8'h00, exp & msk});
    endtask : rdchk

    task automatic wait_tick(output int cnt);
        cnt = 0;
        do begin
            @(posedge core_clk);
            #1 cnt++;
        end while (tick16 !== 1'b1 && cnt < 5000);
    endtask : wait_tick

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 chk_val({dtr_n, rts_n, aux_output_one_n, aux_output_two_n, modem_irq, irq}, 16'h3c);
        // baud: low byte then high byte, each write reloads
        foreach (divs[i]) begin
            wr(smsbg_pkg::ADDR_DIV_LO, divs[i][7:0]);
            wr(smsbg_pkg::ADDR_DIV_HI, divs[i][15:8]);
            if (divs[i] != 16'hffff) begin
                wait_tick(n);
                chk_val({15'h0, n <= int'(divs[i]) + 2}, 16'h0001);
                wait_tick(n);
                chk_val(16'(n), divs[i]);
            end
        end
        // modem deltas and the interrupt path
        wr(smsbg_pkg::ADDR_IRQ_EN, 8'h08);
        wr(smsbg_pkg::ADDR_IRQ_MASK, 8'h01);
        rd(smsbg_pkg::ADDR_MODEM_ST, 8'h00, d);
        want <= 4'hf;
        repeat (12) @(posedge core_clk);
        #1 chk_val({14'h0, modem_irq, irq}, 16'h0003);
        rdchk(smsbg_pkg::ADDR_MODEM_ST, 8'h00, 8'hfb, 8'hff);
        rdchk(smsbg_pkg::ADDR_MODEM_ST, 8'h00, 8'hf0, 8'hff);
        @(posedge core_clk);
        #1 chk_val({14'h0, modem_irq, irq}, 16'h0001);
        rdchk(smsbg_pkg::ADDR_IRQ_STAT, 8'h00, 8'h01, 8'h01);
        repeat (2) @(posedge core_clk);
        #1 chk_val({15'h0, irq}, 16'h0000);
        wr(smsbg_pkg::ADDR_IRQ_MASK, 8'h00);
        slow <= 1'b1;
        want <= 4'h0;
        repeat (16) @(posedge core_clk);
        #1 chk_val({14'h0, modem_irq, irq}, 16'h0002);
        rdchk(smsbg_pkg::ADDR_MODEM_ST, 8'h00, 8'h0f, 8'hff);
        wr(smsbg_pkg::ADDR_MODEM_ST, 8'hff);
        rdchk(smsbg_pkg::ADDR_MODEM_ST, 8'h00, 8'h00, 8'hff);
        // loopback: pins asserted but ignored, control bits drive status
        wr(smsbg_pkg::ADDR_MODEM_CTL, 8'h10);
        want <= 4'hf;
        repeat (16) @(posedge core_clk);
        rdchk(smsbg_pkg::ADDR_MODEM_ST, 8'h00, 8'h00, 8'hff);
        chk_val({dtr_n, rts_n, aux_output_one_n, aux_output_two_n}, 16'h000f);
        foreach (lb[i]) begin
            wr(smsbg_pkg::ADDR_MODEM_CTL, lb[i][0]);
            repeat (6) @(posedge core_clk);
            #1 chk_val({15'h0, modem_irq}, 16'h0001);
            rdchk(smsbg_pkg::ADDR_MODEM_ST, 8'h00, lb[i][1], 8'hff);
        end
        // line status: a flag arising during the read is deferred
        rd(smsbg_pkg::ADDR_LINE_STAT, 8'h00, d);
        rdchk(smsbg_pkg::ADDR_LINE_STAT, 8'h01, 8'h00, 8'h01);
        rdchk(smsbg_pkg::ADDR_LINE_STAT, 8'h00, 8'h01, 8'h01);
        rd(smsbg_pkg::ADDR_IRQ_EN, 8'h02, d);
        rdchk(smsbg_pkg::ADDR_LINE_STAT, 8'h02, 8'h02, 8'h02);
        rdchk(smsbg_pkg::ADDR_LINE_STAT, 8'h00, 8'h00, 8'h02);
        // enable low: a divisor write must not land
        clk_en <= 1'b0;
        wr(smsbg_pkg::ADDR_DIV_LO, 8'h07);
        clk_en <= 1'b1;
        rdchk(smsbg_pkg::ADDR_DIV_LO, 8'h00, 8'h05, 8'hff);
        report_and_stop();
    end
endmodule : tb_top
